// ==== common/meter_decoder_pkg.sv ====
// Shared constants and carrier types for the meter function and range decoder
package meter_decoder_pkg;
  localparam int MODE_W = 4;
  localparam int RANGE_W = 4;
  localparam int GROUPS = 4;
  localparam int ADDR_W = 2;
  // Word addresses of the register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_SWITCH = 2'h2;
  // Measurement function codes and prefixes
  localparam logic [3:0] MODE_VOLT = 4'h0;
  localparam logic [3:0] MODE_DIODE = 4'h1;
  localparam logic [3:0] MODE_HBW_AC = 4'h3;
  localparam logic [2:0] MODE_RES_PFX = 3'h4;
  localparam logic [2:0] MODE_CAP_PFX = 3'h5;
  localparam logic [1:0] MODE_DIV_PFX = 2'h0;
  localparam logic [1:0] MODE_RC_PFX = 2'h2;
  // Ohm source field values
  localparam logic [1:0] SRC_HIZ = 2'h0;
  localparam logic [1:0] SRC_AUX5 = 2'h1;
  localparam logic [1:0] SRC_VRFH = 2'h2;
  localparam logic [1:0] SRC_SUPPLY = 2'h3;
  // Ohm source output select codes
  localparam logic [2:0] OHM_HIZ = 3'h0;
  localparam logic [2:0] OHM_AUX5 = 3'h1;
  localparam logic [2:0] OHM_VRFH = 3'h2;
  localparam logic [2:0] OHM_SUPPLY = 3'h3;
  localparam logic [2:0] OHM_ANALOG_GROUND = 3'h4;
  // Fixed reference level set select
  localparam logic [1:0] REF_OFF = 2'h0;
  localparam logic [1:0] REF_INTERNAL = 2'h1;
  localparam logic [1:0] REF_SUPPLY = 2'h2;
  localparam int BYTES_CTRL = 2;

  typedef struct packed {
    logic cap_range_select;
    logic [1:0] ohm_source_field;
    logic timebase_divider_select;
    logic [RANGE_W-1:0] measure_range_field;
    logic [MODE_W-1:0] measure_function_field;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 12'h000;

  typedef struct packed {
    logic cap;
    logic diode;
    logic vsrc;
    logic short_test;
    logic direct_ac;
  } func_flags_t;

  typedef struct packed {
    logic [1:0] g10m;
    logic [GROUPS-1:0][2:0] g3;
  } switch_groups_t;
endpackage

// ==== logic/meter_function_range_decoder.sv ====
// Function, range and source decoder with Avalon-MM control registers
// Function
// - Voltage mode 0000 drives all five function flags low.
// - Mode 0001 raises only diode; mode 0011 raises only vsrc and direct AC.
// - Modes 100x raise vsrc and short; modes 101x raise cap and vsrc only.
// - Range bits a..d steer the 1k, 10k, 100k and 1M groups; 10M uses all four.
// - Term e is the OR of the range bits and f is its complement.
// - In modes 00xx each group is 0 then its bit twice, and 10M is 0 then e.
// - In 1000/1001 each group is its bit three times; 10M is f,1 or f,f.
// - In 1010/1011 groups follow resistance; 10M is f,1 or f,f.
// - Vsrc low turns the reference set off; high picks set by divider select.
// - Without cap the ohm source follows the source field.
// - With cap the ohm source is Vrfh on toggle 0 and ground on toggle 1.
// - The charge toggle is the first comparator output.
// - The cap range bit picks the threshold pair of the comparator.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module meter_function_range_decoder #(
  parameter int DATA_W = 32
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [meter_decoder_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [DATA_W/8-1:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_first_comparator_out,
  output meter_decoder_pkg::func_flags_t o_flags,
  output meter_decoder_pkg::switch_groups_t o_switch,
  output logic [1:0] o_ref_level_sel,
  output logic [2:0] o_ohm_source_sel,
  output logic [1:0] o_cap_threshold_sel
);
  import meter_decoder_pkg::*;

  // Narrow buses cannot carry the switch word
  if (DATA_W < 16 || DATA_W % 8 != 0) begin : g_bad_width
    $error("DATA_W must be a multiple of 8 and at least 16");
  end

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic wait_reg;
  logic wait_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  ctrl_t ctrl_reg;
  ctrl_t ctrl_next;
  logic [BYTES_CTRL*8-1:0] merged;
  logic [DATA_W-1:0] read_mux;

  func_flags_t flags_reg;
  func_flags_t flags_next;
  switch_groups_t switch_reg;
  switch_groups_t switch_next;
  logic [1:0] ref_reg;
  logic [1:0] ref_next;
  logic [2:0] ohm_reg;
  logic [2:0] ohm_next;
  logic [1:0] thr_reg;
  logic [1:0] thr_next;
  logic range_any;
  logic range_none;
  logic [MODE_W-1:0] mode;

  // Read mux over the live register and output state
  always_comb begin
    unique case (i_avs_address)
      ADDR_CTRL: read_mux = DATA_W'(ctrl_reg);
      ADDR_STATUS: read_mux = DATA_W'({ohm_reg, ref_reg, thr_reg, flags_reg});
      ADDR_SWITCH: read_mux = DATA_W'(switch_reg);
      default: read_mux = '0; // Unmapped word reads as zero
    endcase
  end

  // Bus handshake: one wait cycle, then commit at the edge waitrequest is low
  always_comb begin
    bus_state_next = bus_state_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    merged = {{(BYTES_CTRL*8-$bits(ctrl_t)){1'b0}}, ctrl_reg};
    for (int b = 0; b < BYTES_CTRL; b++) begin
      if (i_avs_byteenable[b]) begin
        merged[b*8 +: 8] = i_avs_writedata[b*8 +: 8];
      end
    end
    unique case (bus_state_reg)
      BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          bus_state_next = BUS_ACK;
          wait_next = 1'b0;
          if (i_avs_read) begin
            rdata_next = read_mux;
          end
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
        // Writes to other words are dropped but still answered
        if (i_avs_write && i_avs_address == ADDR_CTRL) begin
          ctrl_next = ctrl_t'(merged[$bits(ctrl_t)-1:0]);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_state_reg <= BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      bus_state_reg <= bus_state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign mode = ctrl_reg.measure_function_field;
  assign range_any = |ctrl_reg.measure_range_field;
  assign range_none = ~range_any;

  // Decoder; registered so each output is a clean flop, costing one cycle
  always_comb begin
    flags_next = '0;
    switch_next = '0;
    if (mode == MODE_DIODE) begin
      flags_next.diode = 1'b1;
    end else if (mode == MODE_HBW_AC) begin
      flags_next.vsrc = 1'b1;
      flags_next.direct_ac = 1'b1;
    end else if (mode[3:1] == MODE_RES_PFX) begin
      flags_next.vsrc = 1'b1;
      flags_next.short_test = 1'b1;
    end else if (mode[3:1] == MODE_CAP_PFX) begin
      flags_next.cap = 1'b1;
      flags_next.vsrc = 1'b1;
    end
    // One range bit per group, bit a on the 1k group
    for (int i = 0; i < GROUPS; i++) begin
      if (mode[3:2] == MODE_DIV_PFX) begin
        switch_next.g3[i] = {1'b0, {2{ctrl_reg.measure_range_field[RANGE_W-1-i]}}};
      end else if (mode[3:2] == MODE_RC_PFX) begin
        switch_next.g3[i] = {3{ctrl_reg.measure_range_field[RANGE_W-1-i]}};
      end
    end
    // 10M group built from e and f
    if (mode[3:2] == MODE_DIV_PFX) begin
      switch_next.g10m = {1'b0, range_any};
    end else if (mode[3:2] == MODE_RC_PFX) begin
      switch_next.g10m = {range_none, mode[0] ? range_none : 1'b1};
    end
    if (!flags_next.vsrc) begin
      ref_next = REF_OFF;
    end else if (ctrl_reg.timebase_divider_select) begin
      ref_next = REF_SUPPLY;
    end else begin
      ref_next = REF_INTERNAL;
    end
    if (flags_next.cap) begin
      ohm_next = i_first_comparator_out ? OHM_ANALOG_GROUND : OHM_VRFH;
    end else begin
      unique case (ctrl_reg.ohm_source_field)
        SRC_HIZ: ohm_next = OHM_HIZ;
        SRC_AUX5: ohm_next = OHM_AUX5;
        SRC_VRFH: ohm_next = OHM_VRFH;
        SRC_SUPPLY: ohm_next = OHM_SUPPLY;
      endcase
    end
    // Pair select, with the phase beside it
    thr_next = {ctrl_reg.cap_range_select, i_first_comparator_out};
  end

  // Outputs refresh every cycle from the held inputs
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_reg <= '0;
      switch_reg <= '0;
      ref_reg <= REF_OFF;
      ohm_reg <= OHM_HIZ;
      thr_reg <= 2'h0;
    end else begin
      flags_reg <= flags_next;
      switch_reg <= switch_next;
      ref_reg <= ref_next;
      ohm_reg <= ohm_next;
      thr_reg <= thr_next;
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_flags = flags_reg;
  assign o_switch = switch_reg;
  assign o_ref_level_sel = ref_reg;
  assign o_ohm_source_sel = ohm_reg;
  assign o_cap_threshold_sel = thr_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Every output is a flop, so each check looks one cycle after the inputs it depends on

  chk_volt_flags_low: assert property (mode == MODE_VOLT |=> o_flags == '0)
    else $error("voltage mode flags not low");
  chk_diode_only: assert property (mode == MODE_DIODE |=> o_flags == 5'h08)
    else $error("diode mode flags wrong");
  chk_hbw_flags: assert property (mode == MODE_HBW_AC |=> o_flags == 5'h05)
    else $error("wideband AC flags wrong");
  chk_res_flags: assert property (mode[3:1] == MODE_RES_PFX |=> o_flags == 5'h06)
    else $error("resistance flags wrong");
  chk_cap_flags: assert property (mode[3:1] == MODE_CAP_PFX |=> o_flags == 5'h14)
    else $error("capacitance flags wrong");
  chk_unlisted_low: assert property (mode == 4'h2 || mode[2] |=> o_flags == '0)
    else $error("unlisted mode raised a flag");
  chk_group_1m_bit: assert property (mode[3:2] == MODE_RC_PFX
    |=> o_switch.g3[3] == {3{$past(ctrl_reg.measure_range_field[0])}})
    else $error("1M group does not follow bit d");
  chk_10m_or_term: assert property (mode[3:2] == MODE_DIV_PFX
    |=> o_switch.g10m == {1'b0, $past(range_any)})
    else $error("10M divider group wrong");
  chk_divider_1k: assert property (mode[3:2] == MODE_DIV_PFX
    |=> o_switch.g3[0] == {1'b0, {2{$past(ctrl_reg.measure_range_field[3])}}})
    else $error("1k divider group wrong");
  chk_res_10m_ff: assert property (mode == 4'h9 |=> o_switch.g10m == {2{$past(range_none)}})
    else $error("resistance II 10M group wrong");
  chk_cap_10m_f1: assert property (mode == 4'hA |=> o_switch.g10m == {$past(range_none), 1'b1})
    else $error("capacitance I 10M group wrong");
  chk_ref_set_sel: assert property (o_ref_level_sel ==
    (!o_flags.vsrc ? REF_OFF : $past(ctrl_reg.timebase_divider_select) ? REF_SUPPLY : REF_INTERNAL))
    else $error("reference set select wrong");
  chk_src_field: assert property (mode[3:1] != MODE_CAP_PFX && ctrl_reg.ohm_source_field == SRC_AUX5
    |=> o_ohm_source_sel == OHM_AUX5)
    else $error("ohm source does not follow field");
  chk_cap_toggle: assert property (mode[3:1] == MODE_CAP_PFX
    |=> o_ohm_source_sel == ($past(i_first_comparator_out) ? OHM_ANALOG_GROUND : OHM_VRFH))
    else $error("cap ohm source wrong");
  chk_toggle_phase: assert property ($rose(i_first_comparator_out) ##1 o_flags.cap
    |-> o_ohm_source_sel == OHM_ANALOG_GROUND && o_cap_threshold_sel[0])
    else $error("charge phase does not follow comparator");
  chk_pair_select: assert property (1'b1 |=> o_cap_threshold_sel[1] == $past(ctrl_reg.cap_range_select))
    else $error("threshold pair select wrong");
  chk_stable_out: assert property ($stable(ctrl_reg) && $stable(i_first_comparator_out)
    |=> $stable(o_flags) && $stable(o_switch) && $stable(o_ohm_source_sel))
    else $error("outputs moved with stable inputs");

  // Remaining group and source codes; the 1M divider group and the Vrfh source code are left without a check
  chk_res_10m_f1: assert property (mode == 4'h8 |=> o_switch.g10m == {$past(range_none), 1'b1})
    else $error("resistance I 10M group wrong");
  chk_res_1k_bit: assert property (mode[3:2] == MODE_RC_PFX
    |=> o_switch.g3[0] == {3{$past(ctrl_reg.measure_range_field[3])}})
    else $error("1k group does not follow bit a");
  chk_res_10k_bit: assert property (mode[3:2] == MODE_RC_PFX
    |=> o_switch.g3[1] == {3{$past(ctrl_reg.measure_range_field[2])}})
    else $error("10k group does not follow bit b");
  chk_group_100k_bit: assert property (mode[3:2] == MODE_RC_PFX
    |=> o_switch.g3[2] == {3{$past(ctrl_reg.measure_range_field[1])}})
    else $error("100k group does not follow bit c");
  chk_cap_10m_ff: assert property (mode == 4'hB |=> o_switch.g10m == {2{$past(range_none)}})
    else $error("capacitance II 10M group wrong");
  chk_divider_10k: assert property (mode[3:2] == MODE_DIV_PFX
    |=> o_switch.g3[1] == {1'b0, {2{$past(ctrl_reg.measure_range_field[2])}}})
    else $error("10k divider group wrong");
  chk_divider_100k: assert property (mode[3:2] == MODE_DIV_PFX
    |=> o_switch.g3[2] == {1'b0, {2{$past(ctrl_reg.measure_range_field[1])}}})
    else $error("100k divider group wrong");
  chk_src_hiz: assert property (mode[3:1] != MODE_CAP_PFX && ctrl_reg.ohm_source_field == SRC_HIZ
    |=> o_ohm_source_sel == OHM_HIZ)
    else $error("ohm source not high impedance");
  chk_src_supply: assert property (mode[3:1] != MODE_CAP_PFX && ctrl_reg.ohm_source_field == SRC_SUPPLY
    |=> o_ohm_source_sel == OHM_SUPPLY)
    else $error("ohm source not supply");

  // Scenario coverage, one per main decode path plus one control word write
  cov_res_mode: cover property (mode == 4'h8 ##1 o_flags.short_test);
  cov_diode_mode: cover property (mode == MODE_DIODE ##1 o_flags.diode);
  cov_cap_cycle: cover property (o_ohm_source_sel == OHM_VRFH && o_flags.cap ##[1:20] o_ohm_source_sel == OHM_ANALOG_GROUND);
  cov_hbw_mode: cover property (o_flags.direct_ac);
  cov_ctrl_write: cover property (i_avs_write && !o_avs_waitrequest && i_avs_address == ADDR_CTRL);
endmodule
`default_nettype wire

// ==== verification/analog_network_model.sv ====
// Behavioural model of the switch network load and the first comparator
`timescale 1ns/100ps
`default_nettype none
module analog_network_model
  import meter_decoder_pkg::*;
#(
  parameter int CHARGE = 6
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_ohm_source_sel,
  input wire logic i_manual,
  input wire logic i_level,
  output logic o_cmp
);
  int lv;
  logic hi;
  // Cap voltage climbs on Vrfh, sinks on ground, holds while the source is elsewhere
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lv <= 0;
      hi <= 1'b0;
    end else begin
      if (i_ohm_source_sel == OHM_VRFH && lv < CHARGE) lv <= lv + 1;
      else if (i_ohm_source_sel == OHM_ANALOG_GROUND && lv > 0) lv <= lv - 1;
      hi <= (lv >= CHARGE) ? 1'b1 : ((lv == 0) ? 1'b0 : hi);
    end
  end
  // Manual mode lets the bench pin the comparator to a chosen level
  assign o_cmp = i_manual ? i_level : hi;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Testbench for the meter decoder: register traffic and decode checks
`timescale 1ns/100ps
`default_nettype none
module tb;
  import meter_decoder_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] adr = 2'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wreq;
  logic cmp;
  logic manual = 1'b1;
  logic lvl = 1'b0;
  func_flags_t flags;
  switch_groups_t sw;
  logic [1:0] refs;
  logic [2:0] ohm;
  logic [1:0] thr;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] got;
  logic [11:0] c;
  logic [4:0] ef;
  logic [13:0] es;
  logic [2:0] eo;
  logic [1:0] er;

  always #5 clk = ~clk;

  meter_function_range_decoder dut (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_first_comparator_out(cmp),
    .o_flags(flags), .o_switch(sw), .o_ref_level_sel(refs), .o_ohm_source_sel(ohm),
    .o_cap_threshold_sel(thr));

  analog_network_model far (.i_core_clk(clk), .i_nrst(nrst), .i_ohm_source_sel(ohm),
    .i_manual(manual), .i_level(lvl), .o_cmp(cmp));

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon access; an edge passes first so a request never re-rises in its release step
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    got = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    chk("bus answer", {31'h0, n < 50}, 32'h1);
  endtask

  task automatic wait_ohm(input logic [2:0] v);
    int n;
    n = 0;
    while (ohm !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("ohm swing", {29'h0, ohm}, {29'h0, v});
  endtask

  // Expected decode from the control word and toggle; unlisted 01xx/11xx give zero groups
  function automatic void expect_dec(input logic [11:0] cv, input logic t);
    logic [3:0] m;
    logic [3:0] r;
    logic e;
    logic [2:0] g;
    m = cv[3:0];
    r = cv[7:4];
    e = |r;
    es = 14'h0000;
    case (m)
      4'h1: ef = 5'h08;
      4'h3: ef = 5'h05;
      4'h8, 4'h9: ef = 5'h06;
      4'hA, 4'hB: ef = 5'h14;
      default: ef = 5'h00;
    endcase
    for (int i = 0; i < 4; i++) begin
      g = {3{r[3-i]}};
      if (m[3:2] == 2'h0) g[2] = 1'b0;
      if (m[2]) g = 3'h0;
      es[3*i +: 3] = g;
    end
    if (m[3:2] == 2'h0) es[13:12] = {1'b0, e};
    else if (m[3:2] == 2'h2) es[13:12] = {~e, m[0] ? ~e : 1'b1};
    case (cv[10:9])
      SRC_HIZ: eo = OHM_HIZ;
      SRC_AUX5: eo = OHM_AUX5;
      SRC_VRFH: eo = OHM_VRFH;
      default: eo = OHM_SUPPLY;
    endcase
    if (ef[4]) eo = t ? OHM_ANALOG_GROUND : OHM_VRFH;
    er = !ef[2] ? REF_OFF : (cv[8] ? REF_SUPPLY : REF_INTERNAL);
  endfunction

  // Hang guard: the whole sequence needs only about a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("ohm after reset", {29'h0, ohm}, {29'h0, OHM_HIZ});
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", got, 32'h0);
    // Every mode and toggle, once with live range bits and once with range zero
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 16; m++) begin
        for (int t = 0; t < 2; t++) begin
          c = {p[0] ^ m[2], m[1:0] ^ {p[0], t[0]}, m[0] ^ t[0], p[0] ? 4'h0 : 4'(m * 5), 4'(m)};
          lvl <= t[0];
          bus(1'b1, ADDR_CTRL, {20'hFFFFF, c});
          repeat (3) @(posedge clk);
          expect_dec(c, t[0]);
          chk("flags", {27'h0, flags}, {27'h0, ef});
          chk("switch", {18'h0, sw}, {18'h0, es});
          chk("ref", {30'h0, refs}, {30'h0, er});
          chk("ohm", {29'h0, ohm}, {29'h0, eo});
          chk("thr", {30'h0, thr}, {30'h0, c[11], t[0]});
          bus(1'b0, ADDR_STATUS, 32'h0);
          chk("status", got, {20'h0, eo, er, c[11], t[0], ef});
          bus(1'b0, ADDR_SWITCH, 32'h0);
          chk("switch word", got, {18'h0, es});
          bus(1'b0, ADDR_CTRL, 32'h0);
          chk("ctrl", got, {20'h0, c});
        end
      end
    end
    // Read-only and unmapped words leave the control word alone
    bus(1'b1, ADDR_STATUS, 32'h00000FFF);
    bus(1'b1, 2'h3, 32'h00000FFF);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl kept", got, {20'h0, c});
    bus(1'b0, 2'h3, 32'h0);
    chk("unmapped", got, 32'h0);
    // Lane 0 alone moves mode and range; the upper control bits stay put
    be <= 4'h1;
    bus(1'b1, ADDR_CTRL, 32'h00000F5A);
    be <= 4'hF;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl lane0", got, {20'h0, c[11:8], 8'h5A});
    // Mid-run reset returns bus, control word and decode to their idle values
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ohm in reset", {29'h0, ohm}, {29'h0, OHM_HIZ});
    chk("flags in reset", {27'h0, flags}, 32'h0);
    chk("wait in reset", {31'h0, wreq}, 32'h1);
    nrst <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl after reset", got, 32'h0);
    // Free-running charge and discharge driven by the comparator model
    manual <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h0000000A);
    wait_ohm(OHM_ANALOG_GROUND);
    wait_ohm(OHM_VRFH);
    results();
  end
endmodule
`default_nettype wire
